//--- hdl/fault_unit_cfg.svh
// Purpose: offsets, field positions and reset values for the fault override unit
// Assumes: 32-bit register bus, word-aligned registers
// Notes: definitions only
`ifndef FAULT_UNIT_CFG_SVH
`define FAULT_UNIT_CFG_SVH
// register byte addresses
`define OFS_FLTA_CFG 6'h00
`define OFS_FLTB_CFG 6'h04
`define OFS_FLT_STAT 6'h08
`define OFS_PWM_CTRL 6'h0C
`define OFS_PORT_IO 6'h10
// configuration register fields
`define FLD_STATE_LSB 0
`define FLD_STATE_MSB 7
`define FLD_MODE 7
`define FLD_EN_LSB 8
`define FLD_EN_MSB 11
`define FLD_STATE_HI 15
`define CFG_RST 16'h0000
// status fields
`define ST_AIF 0
`define ST_BIF 1
`define ST_AIE 2
`define ST_BIE 3
`define ST_AACT 4
`define ST_BACT 5
// control fields
`define CT_RUN 0
`define CT_CENTER 1
`define CT_IUE 2
`define CT_HIGH_SIDE_POLARITY 3
`define CT_LOW_SIDE_POLARITY 4
`define CT_CMPL_LSB 5
`define CT_CMPL_MSB 8
`define CT_RST 9'h000
// port pin fields
`define PIO_DIR_A 0
`define PIO_DIR_B 1
`define PIO_OUT_A 2
`define PIO_OUT_B 3
`define PIO_LVL_A 4
`define PIO_LVL_B 5
`define PIO_RST 4'h3
`define NPAIR 4
`define CNT_W 15
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- hdl/fault_unit_pkg.sv
// Purpose: shared types for the fault override unit
// Assumes: nothing
// Notes: numbers live in fault_unit_cfg.svh
package fault_unit_pkg;
	typedef logic [31:0] word_type;
	typedef logic [5:0] addr_type;
	typedef logic [7:0] pin_vec_type;
	typedef logic [14:0] count_type;
	// per-input hold state
	typedef enum logic [2:0] {
		FS_IDLE = 3'b001,
		FS_HOLD = 3'b010,
		FS_WAIT = 3'b100
	} fault_state_type;
endpackage

//--- hdl/fault_channel.sv
// Purpose: hold state for one fault input
// Assumes: synchronised active-high asserted input, one clock
// Notes: instantiated once per fault input
`timescale 1ns/100ps
`include "fault_unit_cfg.svh"
module fault_channel
	import fault_unit_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// fault status
	input wire logic asserted,
	input wire logic armed,
	input wire logic latched_mode,
	input wire logic flag,
	input wire logic boundary,
	// result
	output logic holding
);
	import fault_unit_pkg::*;
	fault_state_type state_r;
	fault_state_type state_nxt;
	wire logic live = asserted && armed;
	// exit waits for input high, flag clear in latched mode, then a boundary
	wire logic released = !asserted && !(latched_mode && flag);
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			FS_IDLE: begin
				if (live) begin
					state_nxt = FS_HOLD;
				end
			end
			FS_HOLD: begin
				if (!armed) begin
					state_nxt = FS_IDLE;
				end else if (released) begin
					state_nxt = boundary ? FS_IDLE : FS_WAIT;
				end
			end
			FS_WAIT: begin
				if (live) begin
					state_nxt = FS_HOLD;
				end else if (boundary) begin
					state_nxt = FS_IDLE;
				end
			end
			default: begin
				state_nxt = FS_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= FS_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end
	// entry acts at once, not one cycle later
	assign holding = live || (state_r != FS_IDLE);
endmodule

//--- hdl/pwm_fault_override_unit.sv
// Notes on behaviour
// - enabled asserted fault forces programmed pin states in hardware
// - fault inputs are active low; wired-OR sources pull low
// - each input has its own flag, enable and request
// - four pair enables per configuration register select affected pairs
// - all enables clear: no effect and no interrupt
// - eight state bits: clear drives inactive, set drives active
// - levels resolved through high-side and low-side polarity
// - complementary pair both active: only high side active
// - latched mode holds until input high and flag cleared, then boundary
// - flag cleared while input low keeps fault until input high
// - cycle-by-cycle holds while low, resumes at boundary ignoring immediate update
// - bit 7 selects each input's mode
// - entry immediate, overrides duty and manual override
// - restore at count zero, or zero or period when center aligned
// - time base stopped: restore at once
// - input A states win over input B on shared pairs
// - A clearing with B still asserted moves to B states at boundary
// - latched A blocks B states or normal until flag cleared and input high
// - fault input level readable in the port data register
//
// Purpose: fault override stage of a multi-pair PWM, AXI4-Lite registers
// Assumes: 20 MHz clk_sys, synchronous active-high rst, time base external
// Notes: sits after duty compare and manual override, before the pins
`timescale 1ns/100ps
`include "fault_unit_cfg.svh"
module pwm_fault_override_unit
	import fault_unit_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// axi4-lite write address and data
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire fault_unit_pkg::addr_type s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire fault_unit_pkg::word_type s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire fault_unit_pkg::addr_type s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output fault_unit_pkg::word_type s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// shared fault pins, active low
	input wire logic fault_input_a_in,
	output logic fault_input_a_out,
	output logic fault_input_a_oe,
	input wire logic fault_input_b_in,
	output logic fault_input_b_out,
	output logic fault_input_b_oe,
	// time base
	input wire fault_unit_pkg::count_type timebase_count,
	input wire fault_unit_pkg::count_type timebase_period,
	// normal pwm levels, active-true, bit 2p high side, 2p+1 low side
	input wire fault_unit_pkg::pin_vec_type pwm_normal,
	// pins and requests
	output fault_unit_pkg::pin_vec_type pwm_pins,
	output logic fault_a_irq,
	output logic fault_b_irq
);
	import fault_unit_pkg::*;

	// ==========================================================
	// registers
	logic [15:0] fault_a_configuration_r;
	logic [15:0] fault_b_configuration_r;
	logic [8:0] ctrl_r;
	logic [3:0] pio_r;
	logic fault_a_irq_flag_r;
	logic fault_b_irq_flag_r;
	logic irq_en_a_r;
	logic irq_en_b_r;
	logic sync_a1_r;
	logic sync_a2_r;
	logic sync_b1_r;
	logic sync_b2_r;
	pin_vec_type pins_r;

	// ==========================================================
	// input synchronisers
	// pin level passes two flops before any decision reads it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync_a1_r <= 1'b1;
			sync_a2_r <= 1'b1;
			sync_b1_r <= 1'b1;
			sync_b2_r <= 1'b1;
		end else begin
			sync_a1_r <= fault_input_a_in;
			sync_a2_r <= sync_a1_r;
			sync_b1_r <= fault_input_b_in;
			sync_b2_r <= sync_b1_r;
		end
	end
	// low means fault; the pad resolves software drive and wired-OR
	wire logic a_asserted = !sync_a2_r;
	wire logic b_asserted = !sync_b2_r;
	// port output drive lets software assert a fault itself
	assign fault_input_a_oe = !pio_r[`PIO_DIR_A];
	assign fault_input_a_out = pio_r[`PIO_OUT_A];
	assign fault_input_b_oe = !pio_r[`PIO_DIR_B];
	assign fault_input_b_out = pio_r[`PIO_OUT_B];

	// ==========================================================
	// configuration decode
	wire logic [3:0] fault_a_pair_enables = fault_a_configuration_r[`FLD_EN_MSB:`FLD_EN_LSB];
	wire logic [3:0] fault_b_pair_enables = fault_b_configuration_r[`FLD_EN_MSB:`FLD_EN_LSB];
	wire logic fault_a_mode_select = fault_a_configuration_r[`FLD_MODE];
	wire logic fault_b_mode_select = fault_b_configuration_r[`FLD_MODE];
	// mode bit overlaps pin 7 state bit, so pin 7 state moves to bit 15
	wire pin_vec_type state_a = {fault_a_configuration_r[`FLD_STATE_HI],
		fault_a_configuration_r[`FLD_STATE_MSB-1:`FLD_STATE_LSB]};
	wire pin_vec_type state_b = {fault_b_configuration_r[`FLD_STATE_HI],
		fault_b_configuration_r[`FLD_STATE_MSB-1:`FLD_STATE_LSB]};
	wire logic a_armed = |fault_a_pair_enables;
	wire logic b_armed = |fault_b_pair_enables;
	// mode bit clear means latched
	wire logic a_latched = !fault_a_mode_select;
	wire logic b_latched = !fault_b_mode_select;
	wire logic timebase_run = ctrl_r[`CT_RUN];
	wire logic center_mode = ctrl_r[`CT_CENTER];
	wire logic immediate_update_enable = ctrl_r[`CT_IUE];
	wire logic high_side_polarity = ctrl_r[`CT_HIGH_SIDE_POLARITY];
	wire logic low_side_polarity = ctrl_r[`CT_LOW_SIDE_POLARITY];
	wire logic [3:0] cmpl_mode = ctrl_r[`CT_CMPL_MSB:`CT_CMPL_LSB];

	// ==========================================================
	// restore boundary; immediate update deliberately not consulted
	wire logic at_zero = (timebase_count == '0);
	wire logic at_period = (timebase_count == timebase_period);
	wire logic boundary = !timebase_run || at_zero
		|| (center_mode && at_period);

	// ==========================================================
	// per-input hold machines
	logic hold_a;
	logic hold_b;
	fault_channel u_chan_a (
		.clk_sys(clk_sys),
		.rst(rst),
		.asserted(a_asserted),
		.armed(a_armed),
		.latched_mode(a_latched),
		.flag(fault_a_irq_flag_r),
		.boundary(boundary),
		.holding(hold_a)
	);
	fault_channel u_chan_b (
		.clk_sys(clk_sys),
		.rst(rst),
		.asserted(b_asserted),
		.armed(b_armed),
		.latched_mode(b_latched),
		.flag(fault_b_irq_flag_r),
		.boundary(boundary),
		.holding(hold_b)
	);

	// ==========================================================
	// output selection per pair
	pin_vec_type forced;
	genvar gp;
	generate
		for (gp = 0; gp < `NPAIR; gp = gp + 1) begin : g_pair
			wire logic use_a = hold_a && fault_a_pair_enables[gp];
			wire logic use_b = hold_b && fault_b_pair_enables[gp];
			// a wins while it holds, latched a included
			wire logic [1:0] st = use_a ? state_a[2*gp+1:2*gp]
				: state_b[2*gp+1:2*gp];
			wire logic [1:0] raw = (use_a || use_b) ? st
				: pwm_normal[2*gp+1:2*gp];
			// complementary pair: high side takes priority
			wire logic lo_act = raw[1] && !(cmpl_mode[gp] && raw[0]);
			assign forced[2*gp] = raw[0] ^ !high_side_polarity;
			assign forced[2*gp+1] = lo_act ^ !low_side_polarity;
		end
	endgenerate
	// pins are registered for clean outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pins_r <= {`NPAIR{!low_side_polarity, !high_side_polarity}};
		end else begin
			pins_r <= forced;
		end
	end
	assign pwm_pins = pins_r;

	// ==========================================================
	// axi4-lite slave; one write and one read at a time
	logic aw_got_r;
	logic w_got_r;
	addr_type aw_addr_r;
	word_type w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	word_type rdata_r;
	logic [1:0] rresp_r;
	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	wire logic aw_fire = s_axi_awvalid && s_axi_awready;
	wire logic w_fire = s_axi_wvalid && s_axi_wready;
	wire logic ar_fire = s_axi_arvalid && s_axi_arready;
	wire logic wr_go = (aw_got_r || aw_fire) && (w_got_r || w_fire);
	wire addr_type wa = aw_got_r ? aw_addr_r : s_axi_awaddr;
	wire word_type wd = w_got_r ? w_data_r : s_axi_wdata;
	wire logic [3:0] ws = w_got_r ? w_strb_r : s_axi_wstrb;
	wire logic wr_a = wr_go && wa == `OFS_FLTA_CFG;
	wire logic wr_b = wr_go && wa == `OFS_FLTB_CFG;
	wire logic wr_st = wr_go && wa == `OFS_FLT_STAT && ws[0];
	wire logic wr_ct = wr_go && wa == `OFS_PWM_CTRL;
	wire logic wr_io = wr_go && wa == `OFS_PORT_IO && ws[0];
	wire logic wr_hit = wr_a || wr_b || wr_go && (wa == `OFS_FLT_STAT
		|| wa == `OFS_PWM_CTRL || wa == `OFS_PORT_IO);
	wire logic [15:0] wmask = {{8{ws[1]}}, {8{ws[0]}}};
	// channel handshake bookkeeping
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else begin
			aw_got_r <= wr_go ? 1'b0 : (aw_got_r || aw_fire);
			w_got_r <= wr_go ? 1'b0 : (w_got_r || w_fire);
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (aw_fire) begin
			aw_addr_r <= s_axi_awaddr;
		end
		if (w_fire) begin
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end
	end
	// configuration and control stores
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fault_a_configuration_r <= `CFG_RST;
			fault_b_configuration_r <= `CFG_RST;
			ctrl_r <= `CT_RST;
			pio_r <= `PIO_RST;
			irq_en_a_r <= 1'b0;
			irq_en_b_r <= 1'b0;
		end else begin
			if (wr_a) begin
				fault_a_configuration_r <= (fault_a_configuration_r & ~wmask)
					| (wd[15:0] & wmask);
			end
			if (wr_b) begin
				fault_b_configuration_r <= (fault_b_configuration_r & ~wmask)
					| (wd[15:0] & wmask);
			end
			if (wr_ct && ws[0] && ws[1]) begin
				ctrl_r <= wd[8:0];
			end
			if (wr_io) begin
				pio_r <= wd[3:0];
			end
			if (wr_st) begin
				irq_en_a_r <= wd[`ST_AIE];
				irq_en_b_r <= wd[`ST_BIE];
			end
		end
	end
	// flags: set when an armed input is low; set wins over write-one-clear
	wire logic set_a = a_asserted && a_armed;
	wire logic set_b = b_asserted && b_armed;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fault_a_irq_flag_r <= 1'b0;
			fault_b_irq_flag_r <= 1'b0;
		end else begin
			fault_a_irq_flag_r <= set_a || (fault_a_irq_flag_r && !(wr_st && wd[`ST_AIF]));
			fault_b_irq_flag_r <= set_b || (fault_b_irq_flag_r && !(wr_st && wd[`ST_BIF]));
		end
	end
	assign fault_a_irq = fault_a_irq_flag_r && irq_en_a_r;
	assign fault_b_irq = fault_b_irq_flag_r && irq_en_b_r;
	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (s_axi_araddr)
			`OFS_FLTA_CFG: rd_mux[15:0] = fault_a_configuration_r;
			`OFS_FLTB_CFG: rd_mux[15:0] = fault_b_configuration_r;
			`OFS_FLT_STAT: rd_mux[5:0] = {hold_b, hold_a, irq_en_b_r, irq_en_a_r,
				fault_b_irq_flag_r, fault_a_irq_flag_r};
			`OFS_PWM_CTRL: rd_mux[8:0] = ctrl_r;
			`OFS_PORT_IO: rd_mux[5:0] = {sync_b2_r, sync_a2_r, pio_r};
			default: rd_mux = '0;
		endcase
	end
	wire logic rd_hit = s_axi_araddr == `OFS_FLTA_CFG || s_axi_araddr == `OFS_FLTB_CFG
		|| s_axi_araddr == `OFS_FLT_STAT || s_axi_araddr == `OFS_PWM_CTRL
		|| s_axi_araddr == `OFS_PORT_IO;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	a_flag_sets: assert property (@(posedge clk_sys) disable iff (rst)
		set_a |=> fault_a_irq_flag_r) else $error("flag a not set");
	a_idle_no_flag: assert property (@(posedge clk_sys) disable iff (rst)
		!a_armed && !fault_a_irq_flag_r |=> !fault_a_irq_flag_r)
		else $error("flag a set while disarmed");
	a_entry_now: assert property (@(posedge clk_sys) disable iff (rst)
		a_asserted && a_armed |-> hold_a) else $error("entry not immediate");
	a_latch_keep: assert property (@(posedge clk_sys) disable iff (rst)
		hold_a && a_asserted |=> hold_a || !a_armed) else $error("released while low");
	a_cmpl_safe: assert property (@(posedge clk_sys) disable iff (rst)
		cmpl_mode[0] && high_side_polarity && low_side_polarity
		|=> !(pwm_pins[0] && pwm_pins[1])) else $error("both sides active");
	a_sync_lag: assert property (@(posedge clk_sys) disable iff (rst)
		!fault_input_a_in ##1 !fault_input_a_in |=> !sync_a2_r) else $error("sync lag");
	a_exit_boundary: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(hold_a) && $past(a_armed) |-> $past(boundary)) else $error("exit off boundary");
	a_latch_flag: assert property (@(posedge clk_sys) disable iff (rst)
		hold_a && a_latched && fault_a_irq_flag_r && a_armed |=> hold_a)
		else $error("latched exit with flag set");
	c_fault_a: cover property (@(posedge clk_sys) $rose(hold_a));
	c_both: cover property (@(posedge clk_sys) hold_a && hold_b);
	c_exit: cover property (@(posedge clk_sys) $fell(hold_b));
	// exit with immediate update set must still wait for a boundary
	c_exit_iue: cover property (@(posedge clk_sys) immediate_update_enable && $fell(hold_b));
endmodule

//--- verif/fault_source.sv
// Purpose: external fault circuitry on the two shared fault pins
// Assumes: pull-up on each line, every source only pulls low
// Notes: while the device drives its pin, outside sources cannot reach it
`timescale 1ns/100ps
module fault_source (
	// requests from the bench
	input wire logic pull_a,
	input wire logic pull_b,
	// device drive of the shared pins
	input wire logic out_a,
	input wire logic oe_a,
	input wire logic out_b,
	input wire logic oe_b,
	// resolved pad levels
	output logic level_a,
	output logic level_b
);
	// ==========================================================
	// pin resolution
	// a released line floats up through the pull-up, never to a stale value
	assign level_a = oe_a ? out_a : !pull_a;
	assign level_b = oe_b ? out_b : !pull_b;
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the fault override unit
// Assumes: 20 MHz clk_sys, registers reached over axi4-lite
// Notes: expected pins come from a small model driven by the bench's own copies
`timescale 1ns/100ps
`include "fault_unit_cfg.svh"
module tb;
	import fault_unit_pkg::*;
	// ==========================================================
	// signals
	logic clk_sys = 0;
	logic rst = 1;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1;
	addr_type s_axi_awaddr = '0, s_axi_araddr = '0;
	word_type s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic lvl_a, lvl_b, out_a, oe_a, out_b, oe_b, irq_a, irq_b;
	logic pull_a = 0, pull_b = 0;
	count_type tb_cnt = '0, tb_per = 15'h0014;
	pin_vec_type normal = '0, pins;
	integer seed = 32'h030b_bc1b;
	int n_errors = 0, total_checks = 0;
	logic [15:0] cfg_a = '0, cfg_b = '0;
	logic [8:0] ctrl = '0;

	// clock, half period 25 ns
	always #25 clk_sys = ~clk_sys;

	// ==========================================================
	// design and far side
	pwm_fault_override_unit uut (.clk_sys, .rst,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp,
		.fault_input_a_in(lvl_a), .fault_input_a_out(out_a), .fault_input_a_oe(oe_a),
		.fault_input_b_in(lvl_b), .fault_input_b_out(out_b), .fault_input_b_oe(oe_b),
		.timebase_count(tb_cnt), .timebase_period(tb_per), .pwm_normal(normal),
		.pwm_pins(pins), .fault_a_irq(irq_a), .fault_b_irq(irq_b));
	fault_source src (.pull_a(pull_a), .pull_b(pull_b), .out_a(out_a), .oe_a(oe_a),
		.out_b(out_b), .oe_b(oe_b), .level_a(lvl_a), .level_b(lvl_b));

	// ==========================================================
	// reporting
	task stop_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ==========================================================
	// bus cycles, entered just after a rising edge; ready levels are pre-edge here
	task wr(input addr_type a, input word_type d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		chk(s_axi_bresp, er);
	endtask

	task rchk(input addr_type a, input word_type exp, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		chk(s_axi_rdata, exp);
		chk(s_axi_rresp, er);
	endtask

	task cfg(input logic [15:0] a, input logic [15:0] b);
		cfg_a = a;
		cfg_b = b;
		wr(`OFS_FLTA_CFG, {16'h0000, a}, `RESP_OKAY);
		wr(`OFS_FLTB_CFG, {16'h0000, b}, `RESP_OKAY);
	endtask

	task ct(input logic [8:0] c);
		ctrl = c;
		wr(`OFS_PWM_CTRL, {23'h00_0000, c}, `RESP_OKAY);
	endtask

	// random pin states around a chosen mode and pair enable set
	function automatic logic [15:0] rc(input logic mode, input logic [3:0] en);
		logic [31:0] r;
		r = $random(seed);
		return {r[7], 3'b000, en, mode, r[6:0]};
	endfunction

	// ==========================================================
	// reference model: a wins shared pairs, complementary keeps one side active
	function automatic pin_vec_type expect_pins(input logic fa, input logic fb);
		logic [1:0] act;
		logic [7:0] sa, sb;
		pin_vec_type v;
		sa = {cfg_a[15], cfg_a[6:0]};
		sb = {cfg_b[15], cfg_b[6:0]};
		for (int p = 0; p < 4; p++) begin
			act = normal[2*p+:2];
			if (fb && cfg_b[8+p])
				act = sb[2*p+:2];
			if (fa && cfg_a[8+p])
				act = sa[2*p+:2];
			if (((fa && cfg_a[8+p]) || (fb && cfg_b[8+p])) && ctrl[5+p] && act == 2'b11)
				act = 2'b01;
			v[2*p] = act[0] ~^ ctrl[3];
			v[2*p+1] = act[1] ~^ ctrl[4];
		end
		return v;
	endfunction

	// let the two-flop synchroniser and the pin register settle first
	task pc(input logic fa, input logic fb);
		repeat (6) @(posedge clk_sys);
		chk(pins, expect_pins(fa, fb));
	endtask

	// ==========================================================
	// watchdog, far beyond the roughly 250 cycles the sequence needs
	initial begin
		#250000;
		n_errors++;
		stop_test;
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		@(posedge clk_sys);
		chk(pins, 8'hff);
		rchk(`OFS_FLTA_CFG, 32'h0000_0000, `RESP_OKAY);
		rchk(`OFS_PWM_CTRL, 32'h0000_0000, `RESP_OKAY);
		rchk(`OFS_PORT_IO, 32'h0000_0033, `RESP_OKAY);
		rchk(6'h14, 32'h0000_0000, `RESP_SLVERR);
		wr(6'h18, 32'h0000_0001, `RESP_SLVERR);
		wr(`OFS_FLT_STAT, 32'h0000_000c, `RESP_OKAY);
		// latched a with the time base stopped
		normal <= 8'($random(seed));
		ct(9'h018);
		cfg(rc(0, 4'hf), 16'h0000);
		pull_a <= 1;
		pc(1, 0);
		chk(irq_a, 1'b1);
		rchk(`OFS_FLT_STAT, 32'h0000_001d, `RESP_OKAY);
		for (int k = 0; k < 4; k++) begin
			ct({4'h0, k[1:0], 3'b000});
			pc(1, 0);
		end
		ct(9'h018);
		pull_a <= 0;
		pc(1, 0);
		wr(`OFS_FLT_STAT, 32'h0000_000d, `RESP_OKAY);
		pc(0, 0);
		chk(irq_a, 1'b0);
		pull_a <= 1;
		pc(1, 0);
		wr(`OFS_FLT_STAT, 32'h0000_000d, `RESP_OKAY);
		pc(1, 0);
		// let the released level pass the synchroniser before the clear, or the flag re-sets
		pull_a <= 0;
		pc(1, 0);
		wr(`OFS_FLT_STAT, 32'h0000_000d, `RESP_OKAY);
		pc(0, 0);
		// cycle-by-cycle b, center aligned, immediate update set
		tb_cnt <= 15'h0005;
		ct(9'h01f);
		cfg(16'h0000, rc(1, 4'h6));
		normal <= 8'($random(seed));
		pull_b <= 1;
		pc(0, 1);
		pull_b <= 0;
		pc(0, 1);
		// edge aligned ignores a period match, center aligned takes it
		ct(9'h01d);
		tb_cnt <= tb_per;
		pc(0, 1);
		ct(9'h01f);
		pc(0, 0);
		wr(`OFS_FLT_STAT, 32'h0000_000f, `RESP_OKAY);
		// both inputs on shared pairs, edge aligned
		tb_cnt <= 15'h0005;
		ct(9'h019);
		cfg(rc(0, 4'h3), rc(1, 4'hf));
		pull_a <= 1;
		pull_b <= 1;
		pc(1, 1);
		pull_a <= 0;
		tb_cnt <= 15'h0000;
		pc(1, 1);
		wr(`OFS_FLT_STAT, 32'h0000_000d, `RESP_OKAY);
		pc(0, 1);
		pull_b <= 0;
		pc(0, 0);
		wr(`OFS_FLT_STAT, 32'h0000_000f, `RESP_OKAY);
		// no pair enabled
		cfg(16'h0000, rc(0, 4'h0));
		pull_b <= 1;
		pc(0, 0);
		chk(irq_b, 1'b0);
		pull_b <= 0;
		// complementary pairs all asked active
		ct(9'h1f9);
		cfg(16'h8f7f, 16'h0000);
		pull_a <= 1;
		pc(1, 0);
		pull_a <= 0;
		pc(1, 0);
		wr(`OFS_FLT_STAT, 32'h0000_000f, `RESP_OKAY);
		// fault raised by driving the shared pin low from the port
		ct(9'h018);
		cfg(rc(1, 4'hf), 16'h0000);
		wr(`OFS_PORT_IO, 32'h0000_0002, `RESP_OKAY);
		chk({oe_b, out_b, oe_a, out_a}, 4'h2);
		pc(1, 0);
		rchk(`OFS_PORT_IO, 32'h0000_0022, `RESP_OKAY);
		wr(`OFS_PORT_IO, 32'h0000_000f, `RESP_OKAY);
		chk({oe_b, out_b, oe_a, out_a}, 4'h5);
		pc(0, 0);
		stop_test;
	end
endmodule
